/* File: pkg/dsg_pkg.sv */
package dsg_pkg;
  localparam int NCH = 4;
  localparam int CHW = 2;
  localparam int NLVL = 4;
  localparam int LVLW = 2;
  localparam int CHB_W = 18;
  localparam int MEM_AW = 6;
  localparam int MEM_WORDS = 64;

  // Device register indices; byte address is four times the index
  localparam logic [5:0] R_CTRL = 6'h00;
  localparam logic [5:0] R_CRCC = 6'h01;
  localparam logic [5:0] R_CRCS = 6'h02;
  localparam logic [5:0] R_BASE = 6'h03;
  localparam logic [5:0] R_WRB = 6'h04;
  localparam logic [5:0] R_CHSEL = 6'h05;
  localparam logic [5:0] R_CHA = 6'h06;
  localparam logic [5:0] R_CHB = 6'h07;
  localparam logic [5:0] R_STAT = 6'h08;

  localparam int C_SRST = 0;
  localparam int C_DMA = 1;
  localparam int C_CRC = 2;
  localparam int C_PRIO = 8;
  localparam int A_SRST = 0;
  localparam int A_EN = 1;
  localparam int B_SRC = 0;
  localparam int B_ACT = 8;
  localparam int B_PRIO = 12;
  localparam int B_CMD = 16;
  localparam logic [CHB_W-1:0] CHB_FREE = 18'h3_3000;
  localparam int ST_BUSY = 0;
  localparam int ST_FAULT = 8;

  // Descriptor word 0 layout, word beat size code and last descriptor word index
  localparam int D_VALID = 0;
  localparam int D_BEAT = 1;
  localparam int D_CNT = 16;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] LAST_WORD = 2'h2;

  // System-end address regions, selected by address bits 13:12
  localparam logic [1:0] H_DEV = 2'h0;
  localparam logic [1:0] H_MEM = 2'h1;
  localparam logic [1:0] H_STAT = 2'h2;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLV = 2'h2;
  localparam logic [1:0] RESP_DEC = 2'h3;

  typedef enum logic [2:0] {D_IDLE, D_FETCH, D_RD, D_WR, D_WB} dsg_dev_st_t;
  typedef enum logic [1:0] {S_IDLE, S_DEV, S_BRESP, S_RRESP} dsg_sys_st_t;

  function automatic logic [2:0] dsg_beat_bytes(input logic [1:0] sz);
    case (sz)
      2'h0: dsg_beat_bytes = 3'h1;
      2'h1: dsg_beat_bytes = 3'h2;
      default: dsg_beat_bytes = 3'h4;
    endcase
  endfunction : dsg_beat_bytes

  function automatic logic [3:0] dsg_lane_mask(input logic [1:0] sz, input logic [1:0] a);
    case (sz)
      2'h0: dsg_lane_mask = 4'h1 << a;
      2'h1: dsg_lane_mask = a[1] ? 4'hC : 4'h3;
      default: dsg_lane_mask = 4'hF;
    endcase
  endfunction : dsg_lane_mask
endpackage : dsg_pkg

/* File: pkg/dsg_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dsg_link_if;
  logic reg_req;
  logic reg_we;
  logic [5:0] reg_idx;
  logic [31:0] reg_wdata;
  logic reg_ack;
  logic [31:0] reg_rdata;
  logic mem_req;
  logic mem_we;
  logic [31:0] mem_addr;
  logic [1:0] mem_size;
  logic [31:0] mem_wdata;
  logic mem_ack;
  logic [31:0] mem_rdata;

  modport dev (
    input reg_req, reg_we, reg_idx, reg_wdata, mem_ack, mem_rdata,
    output reg_ack, reg_rdata, mem_req, mem_we, mem_addr, mem_size, mem_wdata
  );
  modport sys (
    output reg_req, reg_we, reg_idx, reg_wdata, mem_ack, mem_rdata,
    input reg_ack, reg_rdata, mem_req, mem_we, mem_addr, mem_size, mem_wdata
  );
endinterface : dsg_link_if
`default_nettype wire

/* File: rtl/dsg_dma_end.sv */
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Controller soft reset only while DMA, CRC off
// - Channel control two locked while channel on; code still lets the CHB_FREE fields (priority, command) change
// - Channel soft reset only while channel off
// - CRC registers writable only while CRC off
// - Load descriptor base before enabling controller
// - Load write-back base before enabling controller
// - Level arbitrates only when its enable set
// - Channel registers follow selected channel number
// - Choose trigger action before channel enable
// - Choose trigger source before channel enable
// - Each beat uses descriptor beat width
// - Descriptor usable only with valid bit set
// - Beats moved equal descriptor beat count
// - Reads use descriptor source address
// - Writes use descriptor destination address
module dsg_dma_end (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic [dsg_pkg::NCH-1:0] trig, // Channel trigger pulses
  output logic [dsg_pkg::NCH-1:0] busy, // Channel moving a block
  output logic [dsg_pkg::NCH-1:0] fault, // Invalid descriptor seen
  dsg_link_if.dev lnk // Register and memory link
);
  import dsg_pkg::*;

  typedef struct packed {
    dsg_dev_st_t st;
    logic dma_global_on;
    logic crc_unit_on;
    logic [NLVL-1:0] priority_level_on;
    logic [15:0] crc_control_reg;
    logic [31:0] crc_checksum_reg;
    logic [31:0] descriptor_base_reg;
    logic [31:0] writeback_base_reg;
    logic [CHW-1:0] channel_select_reg;
    logic [NCH-1:0] ch_on;
    logic [NCH-1:0][CHB_W-1:0] channel_control_two;
    logic [NCH-1:0] pend;
    logic [NCH-1:0] busy;
    logic [NCH-1:0] fault;
    logic [CHW-1:0] cur;
    logic [1:0] k;
    logic [31:0] block_control_word;
    logic [31:0] block_source_address;
    logic [31:0] block_dest_address;
    logic [15:0] block_beat_count;
    logic [31:0] beat_data;
    logic mreq;
    logic mwe;
    logic [31:0] maddr;
    logic [1:0] msize;
    logic [31:0] mwdata;
    logic rack;
    logic [31:0] rdata;
  } dsg_dev_t;

  dsg_dev_t r;
  dsg_dev_t next_r;

  always_comb
  begin
    logic [31:0] rd;
    logic [CHW-1:0] pick;
    logic found;
    logic [LVLW-1:0] best;
    logic [LVLW-1:0] lv;
    logic [CHW-1:0] sel;
    logic [1:0] bw;
    logic [31:0] slot;
    logic [31:0] nxt_src;
    logic [31:0] nxt_dst;
    rd = '0;
    pick = '0;
    found = 1'b0;
    best = '0;
    lv = '0;
    next_r = r;
    sel = r.channel_select_reg;
    bw = r.block_control_word[D_BEAT +: 2];
    slot = {26'h0, r.cur, 4'h0};
    nxt_src = r.block_source_address + 32'(dsg_beat_bytes(bw));
    nxt_dst = r.block_dest_address + 32'(dsg_beat_bytes(bw));

    // Register port: one answer per request, request held until answered
    next_r.rack = 1'b0;
    case (lnk.reg_idx)
      R_CTRL:
      begin
        rd[C_DMA] = r.dma_global_on;
        rd[C_CRC] = r.crc_unit_on;
        rd[C_PRIO +: NLVL] = r.priority_level_on;
      end
      R_CRCC: rd[15:0] = r.crc_control_reg;
      R_CRCS: rd = r.crc_checksum_reg;
      R_BASE: rd = r.descriptor_base_reg;
      R_WRB: rd = r.writeback_base_reg;
      R_CHSEL: rd[CHW-1:0] = sel;
      R_CHA: rd[A_EN] = r.ch_on[sel];
      R_CHB: rd[CHB_W-1:0] = r.channel_control_two[sel];
      R_STAT:
      begin
        rd[ST_BUSY +: NCH] = r.busy;
        rd[ST_FAULT +: NCH] = r.fault;
      end
      default: rd = '0;
    endcase

    if (lnk.mem_ack)
      next_r.mreq = 1'b0;

    // Transfer engine
    case (r.st)
      D_IDLE:
      begin
        for (int c = 0; c < NCH; c++)
        begin
          lv = r.channel_control_two[c][B_PRIO +: LVLW];
          if (r.pend[c] && r.ch_on[c] && r.priority_level_on[lv] && (!found || lv > best))
          begin
            found = 1'b1;
            best = lv;
            pick = CHW'(c);
          end
        end
        if (r.dma_global_on && found)
        begin
          next_r.cur = pick;
          next_r.pend[pick] = 1'b0;
          next_r.busy[pick] = 1'b1;
          next_r.k = '0;
          next_r.st = D_FETCH;
          next_r.mreq = 1'b1;
          next_r.mwe = 1'b0;
          next_r.msize = SZ_WORD;
          next_r.maddr = r.descriptor_base_reg + {26'h0, pick, 4'h0};
        end
      end
      D_FETCH:
        if (lnk.mem_ack)
        begin
          case (r.k)
            2'h0: next_r.block_control_word = lnk.mem_rdata;
            2'h1: next_r.block_source_address = lnk.mem_rdata;
            default: next_r.block_dest_address = lnk.mem_rdata;
          endcase
          if (r.k != LAST_WORD)
          begin
            next_r.k = r.k + 2'h1;
            next_r.mreq = 1'b1;
            next_r.maddr = r.maddr + 32'h0000_0004;
          end
          else if (!r.block_control_word[D_VALID])
          begin
            // Unusable descriptor parks the channel until software acts
            next_r.fault[r.cur] = 1'b1;
            next_r.ch_on[r.cur] = 1'b0;
            next_r.busy[r.cur] = 1'b0;
            next_r.st = D_IDLE;
          end
          else
          begin
            next_r.block_beat_count = r.block_control_word[D_CNT +: 16];
            next_r.k = '0;
            next_r.mreq = 1'b1;
            if (r.block_control_word[D_CNT +: 16] == 16'h0000)
            begin
              next_r.st = D_WB;
              next_r.mwe = 1'b1;
              next_r.maddr = r.writeback_base_reg + slot;
              next_r.mwdata = r.block_control_word;
            end
            else
            begin
              next_r.st = D_RD;
              next_r.maddr = r.block_source_address;
              next_r.msize = bw;
            end
          end
        end
      D_RD:
        if (lnk.mem_ack)
        begin
          next_r.beat_data = lnk.mem_rdata >> {r.block_source_address[1:0], 3'h0};
          next_r.st = D_WR;
          next_r.mreq = 1'b1;
          next_r.mwe = 1'b1;
          next_r.maddr = r.block_dest_address;
          next_r.mwdata = (lnk.mem_rdata >> {r.block_source_address[1:0], 3'h0})
                          << {r.block_dest_address[1:0], 3'h0};
        end
      D_WR:
        if (lnk.mem_ack)
        begin
          next_r.block_source_address = nxt_src;
          next_r.block_dest_address = nxt_dst;
          next_r.block_beat_count = r.block_beat_count - 16'h0001;
          next_r.mreq = 1'b1;
          if (r.block_beat_count == 16'h0001)
          begin
            next_r.st = D_WB;
            next_r.k = '0;
            next_r.msize = SZ_WORD;
            next_r.maddr = r.writeback_base_reg + slot;
            next_r.mwdata = {16'h0000, r.block_control_word[15:0]};
          end
          else
          begin
            next_r.st = D_RD;
            next_r.mwe = 1'b0;
            next_r.maddr = nxt_src;
          end
        end
      D_WB:
        if (lnk.mem_ack)
        begin
          if (r.k != LAST_WORD)
          begin
            next_r.k = r.k + 2'h1;
            next_r.mreq = 1'b1;
            next_r.maddr = r.maddr + 32'h0000_0004;
            next_r.mwdata = (r.k == 2'h0) ? r.block_source_address : r.block_dest_address;
          end
          else
          begin
            next_r.busy[r.cur] = 1'b0;
            next_r.mwe = 1'b0;
            next_r.st = D_IDLE;
          end
        end
      default: next_r.st = D_IDLE;
    endcase

    // A trigger in the grant cycle is kept: set wins over clear
    next_r.pend = next_r.pend | (trig & r.ch_on);

    if (lnk.reg_req && !r.rack)
    begin
      next_r.rack = 1'b1;
      next_r.rdata = rd;
      if (lnk.reg_we)
      begin
        case (lnk.reg_idx)
          R_CTRL:
          begin
            next_r.dma_global_on = lnk.reg_wdata[C_DMA];
            next_r.crc_unit_on = lnk.reg_wdata[C_CRC];
            next_r.priority_level_on = lnk.reg_wdata[C_PRIO +: NLVL];
          end
          R_CRCC:
            if (!r.crc_unit_on)
              next_r.crc_control_reg = lnk.reg_wdata[15:0];
          R_CRCS:
            if (!r.crc_unit_on)
              next_r.crc_checksum_reg = lnk.reg_wdata;
          R_BASE: next_r.descriptor_base_reg = lnk.reg_wdata;
          R_WRB: next_r.writeback_base_reg = lnk.reg_wdata;
          R_CHSEL: next_r.channel_select_reg = lnk.reg_wdata[CHW-1:0];
          R_CHA:
            if (lnk.reg_wdata[A_SRST] && !r.ch_on[sel])
            begin
              next_r.channel_control_two[sel] = '0;
              next_r.pend[sel] = 1'b0;
              next_r.fault[sel] = 1'b0;
            end
            else
              next_r.ch_on[sel] = lnk.reg_wdata[A_EN];
          R_CHB:
            if (r.ch_on[sel])
              next_r.channel_control_two[sel] = (r.channel_control_two[sel] & ~CHB_FREE)
                                                | (lnk.reg_wdata[CHB_W-1:0] & CHB_FREE);
            else
              next_r.channel_control_two[sel] = lnk.reg_wdata[CHB_W-1:0];
          default: next_r.rack = 1'b1;
        endcase
        // Soft reset wipes all state but rack, so a transfer in flight is dropped
        if (lnk.reg_idx == R_CTRL && lnk.reg_wdata[C_SRST] && !r.dma_global_on && !r.crc_unit_on)
        begin
          next_r = '0;
          next_r.rack = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else if (ce)
      r <= next_r;
  end

  assign busy = r.busy;
  assign fault = r.fault;
  assign lnk.reg_ack = r.rack;
  assign lnk.reg_rdata = r.rdata;
  assign lnk.mem_req = r.mreq;
  assign lnk.mem_we = r.mwe;
  assign lnk.mem_addr = r.maddr;
  assign lnk.mem_size = r.msize;
  assign lnk.mem_wdata = r.mwdata;
endmodule : dsg_dma_end
`default_nettype wire

/* File: rtl/dsg_sys_end.sv */
`timescale 1ns/1ps
`default_nettype none
module dsg_sys_end (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic awvalid, // AXI write address valid
  output logic awready, // AXI write address ready
  input wire logic [15:0] awaddr, // AXI write address
  input wire logic wvalid, // AXI write data valid
  output logic wready, // AXI write data ready
  input wire logic [31:0] wdata, // AXI write data
  input wire logic [3:0] wstrb, // AXI byte strobes
  output logic bvalid, // AXI write response valid
  input wire logic bready, // AXI write response ready
  output logic [1:0] bresp, // AXI write response
  input wire logic arvalid, // AXI read address valid
  output logic arready, // AXI read address ready
  input wire logic [15:0] araddr, // AXI read address
  output logic rvalid, // AXI read data valid
  input wire logic rready, // AXI read data ready
  output logic [31:0] rdata, // AXI read data
  output logic [1:0] rresp, // AXI read response
  dsg_link_if.sys lnk // Register and memory link
);
  import dsg_pkg::*;

  typedef struct packed {
    dsg_sys_st_t st;
    logic aw_got;
    logic w_got;
    logic [15:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic isw;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rq;
    logic rwe;
    logic [5:0] ridx;
    logic [31:0] rwd;
    logic base_ok;
    logic wrb_ok;
    logic [31:0] base;
    logic [CHW-1:0] sel;
    logic [NCH-1:0] b_ok;
    logic mack;
    logic [31:0] mrdata;
  } dsg_sys_t;

  dsg_sys_t r;
  dsg_sys_t next_r;
  logic [31:0] sram [MEM_WORDS];
  logic axi_mem_we;
  logic dev_mem_we;
  logic [MEM_AW-1:0] desc_idx;
  logic [3:0] dev_lanes;

  assign dev_mem_we = lnk.mem_req && lnk.mem_we && !r.mack;
  assign dev_lanes = dsg_lane_mask(lnk.mem_size, lnk.mem_addr[1:0]);
  assign desc_idx = r.base[MEM_AW+1:2] + {r.sel, 2'h0};
  assign awready = (r.st == S_IDLE) && !r.aw_got;
  assign wready = (r.st == S_IDLE) && !r.w_got;
  // Reads wait behind any write so only one register access is in flight
  assign arready = (r.st == S_IDLE) && !r.aw_got && !r.w_got && !awvalid && !wvalid;

  always_comb
  begin
    logic refuse;
    logic [5:0] idx;
    refuse = 1'b0;
    idx = r.awaddr[7:2];
    next_r = r;
    axi_mem_we = 1'b0;
    next_r.mack = lnk.mem_req && !r.mack;
    next_r.mrdata = sram[lnk.mem_addr[MEM_AW+1:2]];
    if (awvalid && awready)
    begin
      next_r.aw_got = 1'b1;
      next_r.awaddr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_r.w_got = 1'b1;
      next_r.wdata = wdata;
      next_r.wstrb = wstrb;
    end
    case (r.st)
      S_IDLE:
        if (r.aw_got && r.w_got)
        begin
          next_r.isw = 1'b1;
          next_r.st = S_BRESP;
          next_r.bvalid = 1'b1;
          next_r.bresp = RESP_OK;
          case (r.awaddr[13:12])
            H_DEV:
            begin
              if (idx == R_CTRL && r.wdata[C_DMA])
                refuse = !r.base_ok || !r.wrb_ok || (r.wdata[C_PRIO +: NLVL] == '0);
              if (idx == R_CHA && r.wdata[A_EN])
                refuse = !r.b_ok[r.sel] || !sram[desc_idx][D_VALID];
              if (refuse)
                next_r.bresp = RESP_SLV;
              else
              begin
                next_r.bvalid = 1'b0;
                next_r.st = S_DEV;
                next_r.rq = 1'b1;
                next_r.rwe = 1'b1;
                next_r.ridx = idx;
                next_r.rwd = r.wdata;
                if (idx == R_BASE)
                begin
                  next_r.base = r.wdata;
                  next_r.base_ok = 1'b1;
                end
                if (idx == R_WRB)
                  next_r.wrb_ok = 1'b1;
                if (idx == R_CHSEL)
                  next_r.sel = r.wdata[CHW-1:0];
                if (idx == R_CHB)
                  next_r.b_ok[r.sel] = 1'b1;
                // Forwarded soft resets drop shadows (a channel one only its b_ok bit); one the device end refuses only costs a reload
                if ((idx == R_CTRL && r.wdata[C_SRST]) || (idx == R_CHA && r.wdata[A_SRST]))
                begin
                  next_r.base_ok = idx != R_CTRL && r.base_ok;
                  next_r.wrb_ok = idx != R_CTRL && r.wrb_ok;
                  next_r.b_ok = (idx == R_CTRL) ? '0 : r.b_ok & ~(NCH'(1) << r.sel);
                end
              end
            end
            H_MEM:
              if (dev_mem_we)
              begin
                next_r.st = S_IDLE;
                next_r.bvalid = 1'b0;
              end
              else
                axi_mem_we = 1'b1;
            H_STAT: next_r.bresp = RESP_SLV;
            default: next_r.bresp = RESP_DEC;
          endcase
        end
        else if (arvalid && arready)
        begin
          next_r.isw = 1'b0;
          next_r.st = S_RRESP;
          next_r.rvalid = 1'b1;
          next_r.rresp = RESP_OK;
          next_r.rdata = '0;
          case (araddr[13:12])
            H_DEV:
            begin
              next_r.rvalid = 1'b0;
              next_r.st = S_DEV;
              next_r.rq = 1'b1;
              next_r.rwe = 1'b0;
              next_r.ridx = araddr[7:2];
            end
            H_MEM: next_r.rdata = sram[araddr[MEM_AW+1:2]];
            H_STAT: next_r.rdata = {24'h0000_00, r.b_ok, 2'h0, r.wrb_ok, r.base_ok};
            default: next_r.rresp = RESP_DEC;
          endcase
        end
      S_DEV:
        if (lnk.reg_ack)
        begin
          next_r.rq = 1'b0;
          if (r.isw)
          begin
            next_r.bvalid = 1'b1;
            next_r.st = S_BRESP;
          end
          else
          begin
            next_r.rvalid = 1'b1;
            next_r.rdata = lnk.reg_rdata;
            next_r.st = S_RRESP;
          end
        end
      S_BRESP:
        if (bready)
        begin
          next_r.bvalid = 1'b0;
          next_r.aw_got = 1'b0;
          next_r.w_got = 1'b0;
          next_r.st = S_IDLE;
        end
      S_RRESP:
        if (rready)
        begin
          next_r.rvalid = 1'b0;
          next_r.st = S_IDLE;
        end
      default: next_r.st = S_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else if (ce)
      r <= next_r;
  end

  // Device beats win the port; a software write simply retries
  always_ff @(posedge aclk)
  begin
    if (ce)
      for (int b = 0; b < 4; b++)
      begin
        if (dev_mem_we && dev_lanes[b])
          sram[lnk.mem_addr[MEM_AW+1:2]][8*b +: 8] <= lnk.mem_wdata[8*b +: 8];
        else if (axi_mem_we && r.wstrb[b])
          sram[r.awaddr[MEM_AW+1:2]][8*b +: 8] <= r.wdata[8*b +: 8];
      end
  end

  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign rvalid = r.rvalid;
  assign rdata = r.rdata;
  assign rresp = r.rresp;
  assign lnk.reg_req = r.rq;
  assign lnk.reg_we = r.rwe;
  assign lnk.reg_idx = r.ridx;
  assign lnk.reg_wdata = r.rwd;
  assign lnk.mem_ack = r.mack;
  assign lnk.mem_rdata = r.mrdata;
endmodule : dsg_sys_end
`default_nettype wire

/* File: tb/dsg_link_props.sv */
`timescale 1ns/1ps
`default_nettype none
module dsg_link_props (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset
  input wire logic [dsg_pkg::NCH-1:0] busy, // Busy
  input wire logic reg_req, // Reg request
  input wire logic reg_we, // Reg write
  input wire logic [5:0] reg_idx, // Reg index
  input wire logic [31:0] reg_wdata, // Reg data
  input wire logic reg_ack, // Reg answer
  input wire logic mem_req, // Mem request
  input wire logic mem_we, // Mem write
  input wire logic mem_ack // Mem answer
);
  import dsg_pkg::*;
  // Shadow of forwarded setup; only ever more permissive than the system end
  logic base_seen, wrb_seen, dma_on;
  logic [CHW-1:0] sel;
  logic [NCH-1:0] ctl2_seen;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      base_seen <= 1'b0;
      wrb_seen <= 1'b0;
      dma_on <= 1'b0;
      sel <= '0;
      ctl2_seen <= '0;
    end
    else if (reg_req && reg_we && reg_ack)
    begin
      case (reg_idx)
        R_BASE: base_seen <= 1'b1;
        R_WRB: wrb_seen <= 1'b1;
        R_CTRL: dma_on <= reg_wdata[C_DMA];
        R_CHSEL: sel <= reg_wdata[CHW-1:0];
        R_CHB: ctl2_seen[sel] <= 1'b1;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_req_acked: assert property ($rose(reg_req) |=> reg_ack)
    else $error("register request not answered");
  chk_ack_single: assert property (reg_ack |=> !reg_ack ##1 !reg_req)
    else $error("register answer or request held too long");
  chk_req_stable: assert property ($rose(reg_req) |=> $stable(reg_idx) && $stable(reg_we) && $stable(reg_wdata))
    else $error("register request changed while pending");
  chk_mem_acked: assert property (mem_req && !mem_ack |=> mem_ack)
    else $error("memory request not answered");
  chk_dma_setup: assert property ((reg_req && reg_we && reg_idx == R_CTRL && reg_wdata[C_DMA])
    |-> base_seen && wrb_seen && (|reg_wdata[C_PRIO+:NLVL]))
    else $error("controller enabled before setup");
  chk_chan_setup: assert property ((reg_req && reg_we && reg_idx == R_CHA && reg_wdata[A_EN])
    |-> ctl2_seen[sel])
    else $error("channel enabled before trigger setup");
  chk_busy_on: assert property ($rose(|busy) |-> dma_on)
    else $error("channel granted while controller off");
  chk_fetch_first: assert property ($rose(|busy) |-> ##[0:2] (mem_req && !mem_we))
    else $error("grant not followed by descriptor fetch");
endmodule : dsg_link_props
`default_nettype wire

/* File: tb/dma_setup_and_enable_guard_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dma_setup_and_enable_guard_tb;
  import dsg_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [NCH-1:0] trig = '0;
  logic [NCH-1:0] busy, fault;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [15:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [1:0] bresp, rresp;
  int fail_count = 0;
  int num_checks = 0;
  dsg_link_if lnk_if ();
  dsg_dma_end dsg_dma_end_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .trig(trig), .busy(busy),
    .fault(fault), .lnk(lnk_if.dev));
  dsg_sys_end dsg_sys_end_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .lnk(lnk_if.sys));
  dsg_link_props dsg_link_props_inst (.aclk(aclk), .aresetn(aresetn), .busy(busy), .reg_req(lnk_if.reg_req),
    .reg_we(lnk_if.reg_we), .reg_idx(lnk_if.reg_idx), .reg_wdata(lnk_if.reg_wdata), .reg_ack(lnk_if.reg_ack),
    .mem_req(lnk_if.mem_req), .mem_we(lnk_if.mem_we), .mem_ack(lnk_if.mem_ack));
  initial forever #10 aclk = ~aclk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (awvalid || wvalid);
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    check(32'(bresp), 32'(e));
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    check(rdata, d);
    check(32'(rresp), 32'(e));
  endtask : rd
  task automatic fire(input logic [NCH-1:0] m);
    @(posedge aclk);
    trig <= m;
    @(posedge aclk);
    trig <= '0;
    // Grant lands a cycle after the pulse is taken
    for (int i = 0; i < 10 && busy === '0; i++) @(posedge aclk);
    for (int i = 0; i < 200 && busy !== '0; i++) @(posedge aclk);
  endtask : fire
  task automatic tally_and_finish;
    if (fail_count == 0 && num_checks > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #200_000;
    fail_count++;
    tally_and_finish();
  end
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(16'h0000, 32'h0000_0000, RESP_OK);
    rd(16'h00FC, 32'h0000_0000, RESP_OK);
    wr(16'h2000, 32'h0000_0001, RESP_SLV);
    wr(16'h0000, 32'h0000_0102, RESP_SLV);
    wr(16'h0004, 32'h0000_1234, RESP_OK);
    wr(16'h0000, 32'h0000_0004, RESP_OK);
    wr(16'h0004, 32'h0000_5678, RESP_OK);
    wr(16'h0008, 32'h0000_9ABC, RESP_OK);
    wr(16'h0000, 32'h0000_0005, RESP_OK);
    rd(16'h0004, 32'h0000_1234, RESP_OK);
    rd(16'h0008, 32'h0000_0000, RESP_OK);
    wr(16'h0000, 32'h0000_0000, RESP_OK);
    wr(16'h0000, 32'h0000_0001, RESP_OK);
    rd(16'h0004, 32'h0000_0000, RESP_OK);
    for (int i = 0; i < 4; i++)
    begin
      wr(16'h1040 + 16'(4 * i), 32'hA5A5_0000 + 32'(i), RESP_OK);
      wr(16'h1060 + 16'(4 * i), 32'h0000_0000, RESP_OK);
    end
    // Three word beats, source 0x1040, destination 0x1060
    wr(16'h1010, 32'h0003_0005, RESP_OK);
    wr(16'h1014, 32'h0000_1040, RESP_OK);
    wr(16'h1018, 32'h0000_1060, RESP_OK);
    wr(16'h1020, 32'h0000_0000, RESP_OK);
    wr(16'h000C, 32'h0000_1000, RESP_OK);
    wr(16'h0000, 32'h0000_0102, RESP_SLV);
    wr(16'h0010, 32'h0000_1080, RESP_OK);
    wr(16'h0000, 32'h0000_0002, RESP_SLV);
    wr(16'h0000, 32'h0000_0102, RESP_OK);
    wr(16'h0014, 32'h0000_0001, RESP_OK);
    wr(16'h0018, 32'h0000_0002, RESP_SLV);
    wr(16'h001C, 32'h0000_0205, RESP_OK);
    wr(16'h0014, 32'h0000_0000, RESP_OK);
    rd(16'h001C, 32'h0000_0000, RESP_OK);
    wr(16'h0014, 32'h0000_0001, RESP_OK);
    wr(16'h0018, 32'h0000_0002, RESP_OK);
    wr(16'h001C, 32'h0000_3007, RESP_OK);
    rd(16'h001C, 32'h0000_3205, RESP_OK);
    wr(16'h0018, 32'h0000_0003, RESP_OK);
    rd(16'h0018, 32'h0000_0002, RESP_OK);
    rd(16'h001C, 32'h0000_3205, RESP_OK);
    // Level 3 still off, so the trigger must wait
    fire(4'h2);
    repeat (20) @(posedge aclk);
    check(32'(busy), 32'h0000_0000);
    wr(16'h0000, 32'h0000_0902, RESP_OK);
    for (int i = 0; i < 200 && busy !== '0; i++) @(posedge aclk);
    for (int i = 0; i < 3; i++)
    begin
      rd(16'h1060 + 16'(4 * i), 32'hA5A5_0000 + 32'(i), RESP_OK);
    end
    rd(16'h106C, 32'h0000_0000, RESP_OK);
    rd(16'h1090, 32'h0000_0005, RESP_OK);
    rd(16'h1094, 32'h0000_104C, RESP_OK);
    rd(16'h1098, 32'h0000_106C, RESP_OK);
    rd(16'h1010, 32'h0003_0005, RESP_OK);
    wr(16'h0014, 32'h0000_0002, RESP_OK);
    wr(16'h001C, 32'h0000_0001, RESP_OK);
    wr(16'h0018, 32'h0000_0002, RESP_SLV);
    wr(16'h1020, 32'h0000_0001, RESP_OK);
    wr(16'h0018, 32'h0000_0002, RESP_OK);
    wr(16'h1020, 32'h0000_0000, RESP_OK);
    fire(4'h4);
    check(32'(fault), 32'h0000_0004);
    rd(16'h106C, 32'h0000_0000, RESP_OK);
    tally_and_finish();
  end
endmodule : dma_setup_and_enable_guard_tb
`default_nettype wire
